// >>> hw/selfid_receive_dma.v
// Self-ID receive DMA: captures initialization self-ID quadlets into a host buffer
`timescale 1ns/1ps
`default_nettype none
`include "selfid_receive_dma_regs.vh"

module selfid_receive_dma (
  input  wire        mclk,
  input  wire        rst,
  input  wire [7:0]  reg_addr,
  input  wire [31:0] reg_wdata,
  input  wire        reg_wr,
  input  wire        reg_rd,
  output reg  [31:0] reg_rdata,
  output wire        irq,
  input  wire        bus_reset_start,
  input  wire        bus_reset_end,
  input  wire        subaction_gap,
  input  wire        sid_valid,
  input  wire [31:0] sid_quadlet,
  input  wire        sid_rx_error,
  input  wire [6:0]  bus_time_secs,
  input  wire [12:0] bus_time_cycles,
  output reg         ar_req_valid,
  output reg  [31:0] ar_req_data,
  output wire        mem_wr_valid,
  output reg  [31:0] mem_wr_addr,
  output reg  [31:0] mem_wr_data,
  input  wire        mem_wr_ready,
  input  wire        mem_wr_error
);

  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_RESET = 3'd1;
  localparam [2:0] S_HEAD  = 3'd2;
  localparam [2:0] S_CAPT  = 3'd3;
  localparam [2:0] S_SKIP  = 3'd4;
  localparam [10:0] FULL_VALUE = `COUNT_FULL;

  reg [2:0]            state;
  reg [20:0]           capture_buffer_base;
  reg [7:0]            bus_init_epoch;
  reg [8:0]            captured_quadlet_count;
  reg                  capture_error_flag;
  reg                  accept_identity_packets;
  reg [`EVT_WIDTH-1:0] event_status;
  reg [`EVT_WIDTH-1:0] event_mask;
  reg [9:0]            write_index;
  reg                  seq_error;
  reg                  mem_pend;
  reg                  mem_stale;

  wire mem_done  = mem_pend & mem_wr_ready;
  wire mem_ok    = mem_done & ~mem_wr_error & ~mem_stale;
  wire mem_bad   = mem_done & mem_wr_error & ~mem_stale;
  wire capturing = (state == S_HEAD) | (state == S_CAPT);
  wire sid_take  = (state == S_CAPT) & sid_valid & ~seq_error & ~bus_reset_start;
  wire overflow  = sid_take & (write_index == `BUFFER_QUADLETS);
  wire overrun   = sid_take & ~overflow & mem_pend & ~mem_done;
  wire rx_bad    = capturing & sid_rx_error;
  wire new_error = ~bus_reset_start & capturing & (rx_bad | mem_bad | overflow | overrun);
  wire finish    = ~bus_reset_start & (state == S_CAPT) & subaction_gap;
  wire skip_done = ~bus_reset_start & (state == S_SKIP) & subaction_gap;
  wire clr_hit   = reg_wr & (reg_addr == `ADDR_EVENT_STATUS);

  reg [`EVT_WIDTH-1:0] evt_set;
  always @* begin
    evt_set = {`EVT_WIDTH{1'b0}};
    evt_set[`EVT_BUS_RESET] = bus_reset_start;
    evt_set[`EVT_PHASE_DONE] = finish | skip_done;
    evt_set[`EVT_CAPTURE_ERROR] = new_error;
  end

  assign mem_wr_valid = mem_pend;
  assign irq = |(event_status & event_mask);

  // Register file writes and event bits; a set in the same cycle wins over its clear
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      capture_buffer_base <= `BASE_RESET;
      accept_identity_packets <= 1'b0;
      event_status <= {`EVT_WIDTH{1'b0}};
      event_mask <= {`EVT_WIDTH{1'b0}};
    end else begin
      if (reg_wr && reg_addr == `ADDR_BUFFER_BASE) begin
        capture_buffer_base <= reg_wdata[31:`BASE_LSB];
      end
      if (reg_wr && reg_addr == `ADDR_LINK_SETUP) begin
        accept_identity_packets <= reg_wdata[`ACCEPT_BIT];
      end
      if (reg_wr && reg_addr == `ADDR_EVENT_MASK) begin
        event_mask <= reg_wdata[`EVT_WIDTH-1:0];
      end
      event_status <= (event_status & ~(clr_hit ? reg_wdata[`EVT_WIDTH-1:0] : {`EVT_WIDTH{1'b0}}))
                      | evt_set;
    end
  end

  // Registered read data, one cycle after the strobe
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      reg_rdata <= 32'h00000000;
    end else if (reg_rd) begin
      case (reg_addr)
        `ADDR_BUFFER_BASE: begin
          reg_rdata <= {capture_buffer_base, 11'h000};
        end
        `ADDR_TALLY_STATUS: begin
          reg_rdata <= {capture_error_flag, 7'h00, bus_init_epoch, 5'h00,
                        captured_quadlet_count, 2'b00};
        end
        `ADDR_LINK_SETUP: begin
          reg_rdata <= {31'h00000000, accept_identity_packets};
        end
        `ADDR_EVENT_STATUS: begin
          reg_rdata <= {29'h00000000, event_status};
        end
        `ADDR_EVENT_MASK: begin
          reg_rdata <= {29'h00000000, event_mask};
        end
        default: begin
          reg_rdata <= 32'h00000000;
        end
      endcase
    end else begin
      reg_rdata <= 32'h00000000;
    end
  end

  // Capture sequencer
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      state <= S_IDLE;
      bus_init_epoch <= 8'h00;
      write_index <= 10'h000;
      seq_error <= 1'b0;
    end else if (bus_reset_start) begin
      state <= S_RESET;
      write_index <= 10'h000;
      seq_error <= 1'b0;
    end else begin
      if (new_error) begin
        seq_error <= 1'b1;
      end
      case (state)
        S_IDLE: begin
          state <= S_IDLE;
        end
        S_RESET: begin
          if (bus_reset_end) begin
            if (accept_identity_packets) begin
              state <= S_HEAD;
              bus_init_epoch <= (bus_init_epoch == `EPOCH_MAX) ? 8'h00
                                : bus_init_epoch + 8'h01;
            end else begin
              state <= S_SKIP;
            end
          end
        end
        S_HEAD: begin
          if (!mem_pend || mem_done) begin
            state <= S_CAPT;
            write_index <= 10'h001;
          end
        end
        S_CAPT: begin
          if (subaction_gap) begin
            state <= S_IDLE;
          end else if (sid_take && !overflow && !overrun) begin
            write_index <= write_index + 10'h001;
          end
        end
        S_SKIP: begin
          if (subaction_gap) begin
            state <= S_IDLE;
          end
        end
        default: begin
          state <= S_IDLE;
        end
      endcase
    end
  end

  // Host memory write port, one quadlet in flight
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      mem_pend <= 1'b0;
      mem_stale <= 1'b0;
      mem_wr_addr <= 32'h00000000;
      mem_wr_data <= 32'h00000000;
    end else begin
      if (mem_done) begin
        mem_pend <= 1'b0;
        mem_stale <= 1'b0;
      end
      if (bus_reset_start) begin
        mem_stale <= mem_pend & ~mem_done;
      end else if (state == S_HEAD && (!mem_pend || mem_done)) begin
        mem_pend <= 1'b1;
        mem_stale <= 1'b0;
        mem_wr_addr <= {capture_buffer_base, 11'h000};
        mem_wr_data <= {8'h00, bus_init_epoch, bus_time_secs[2:0],
                        bus_time_cycles};
      end else if (sid_take && !overflow && !overrun && !new_error) begin
        mem_pend <= 1'b1;
        mem_stale <= 1'b0;
        mem_wr_addr <= {capture_buffer_base, write_index[8:0], 2'b00};
        mem_wr_data <= sid_quadlet;
      end
    end
  end

  // Tally status: count, error flag
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      captured_quadlet_count <= 9'h000;
      capture_error_flag <= 1'b0;
    end else begin
      if (bus_reset_start) begin
        captured_quadlet_count <= 9'h000;
      end else if (overflow) begin
        captured_quadlet_count <= FULL_VALUE[8:0];
      end else if (mem_ok && !seq_error && captured_quadlet_count != FULL_VALUE[8:0]) begin
        captured_quadlet_count <= captured_quadlet_count + 9'h001;
      end
      if (new_error) begin
        capture_error_flag <= 1'b1;
      end else if (finish && !seq_error) begin
        capture_error_flag <= 1'b0;
      end
    end
  end

  // Self-ID quadlets outside the initialization phase go to request receive
  always @(posedge mclk or posedge rst) begin
    if (rst) begin
      ar_req_valid <= 1'b0;
      ar_req_data <= 32'h00000000;
    end else begin
      ar_req_valid <= (state == S_IDLE) & sid_valid & ~bus_reset_start;
      if ((state == S_IDLE) && sid_valid) begin
        ar_req_data <= sid_quadlet;
      end
    end
  end

endmodule
`default_nettype wire

// >>> include/selfid_receive_dma_regs.vh
// Offsets, field positions, reset values and limits of the self-ID capture block
`ifndef SELFID_RECEIVE_DMA_REGS_VH
`define SELFID_RECEIVE_DMA_REGS_VH

`define ADDR_BUFFER_BASE   8'h00
`define ADDR_TALLY_STATUS  8'h04
`define ADDR_LINK_SETUP    8'h08
`define ADDR_EVENT_STATUS  8'h0c
`define ADDR_EVENT_MASK    8'h10

`define BASE_LSB           11
`define EPOCH_LSB          16
`define COUNT_LSB          2
`define ERROR_BIT          31
`define ACCEPT_BIT         0

`define EVT_BUS_RESET      0
`define EVT_PHASE_DONE     1
`define EVT_CAPTURE_ERROR  2
`define EVT_WIDTH          3

`define BASE_RESET         21'h000000
`define EPOCH_MAX          8'hff
`define COUNT_FULL         11'h7ff
`define BUFFER_QUADLETS    10'h200

`endif

// >>> testbench/host_mem_model.sv
// Host memory model taking capture writes with random stalls
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
  input  wire logic        mclk,
  input  wire logic        mem_wr_valid,
  input  wire logic [31:0] mem_wr_addr,
  input  wire logic [31:0] mem_wr_data,
  input  wire logic        inject_err,
  output var  logic        mem_wr_ready,
  output wire logic        mem_wr_error
);
  logic [31:0] mem [0:511];
  int          n_acc = 0;
  initial mem_wr_ready = 1'b0;
  always @(posedge mclk) begin
    mem_wr_ready <= ($urandom % 3) != 0;
    if (mem_wr_valid && mem_wr_ready && !inject_err) begin
      mem[mem_wr_addr[10:2]] <= mem_wr_data;
      n_acc <= n_acc + 1;
    end
  end
  assign mem_wr_error = mem_wr_ready & inject_err;
endmodule
`default_nettype wire

// >>> testbench/selfid_receive_dma_bench.sv
// Random and corner-case bench for the self-ID capture block
`timescale 1ns/1ps
`default_nettype none
module selfid_receive_dma_bench;
  logic        mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0, sid_valid = 0, herr = 0;
  logic        irq, ar_req_valid, mem_wr_valid, mem_wr_ready, mem_wr_error;
  logic [7:0]  reg_addr = 0, ep;
  logic [3:0]  evt = 0;
  logic [6:0]  secs = 0;
  logic [12:0] cyc = 0;
  logic [31:0] reg_wdata = 0, sid_quadlet = 0, reg_rdata, ar_req_data, mem_wr_addr, mem_wr_data;
  logic [31:0] d, b, hi = 0, ar_seen = 0, sent [0:511];
  int          n_mismatch = 0, num_checks = 0, n_cyc = 0, k;
  selfid_receive_dma i_dut (.mclk(mclk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq(irq),
    .bus_reset_start(evt[3]), .bus_reset_end(evt[2]), .subaction_gap(evt[1]),
    .sid_rx_error(evt[0]), .sid_valid(sid_valid), .sid_quadlet(sid_quadlet),
    .bus_time_secs(secs), .bus_time_cycles(cyc), .ar_req_valid(ar_req_valid),
    .ar_req_data(ar_req_data), .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready), .mem_wr_error(mem_wr_error));
  host_mem_model i_mem (.mclk(mclk), .mem_wr_valid(mem_wr_valid), .mem_wr_addr(mem_wr_addr),
    .mem_wr_data(mem_wr_data), .inject_err(herr), .mem_wr_ready(mem_wr_ready),
    .mem_wr_error(mem_wr_error));
  initial forever #25 mclk = ~mclk;
  always @(posedge mclk) begin
    if (mem_wr_valid && mem_wr_ready) hi <= {11'h0, mem_wr_addr[31:11]};
    if (ar_req_valid) ar_seen <= ar_req_data;
  end
  always @(posedge mclk) begin
    n_cyc++;
    secs <= $urandom;
    cyc <= $urandom;
    if (n_cyc == 40000) begin
      n_mismatch++;
      report_and_stop();
    end
  end
  task report_and_stop;
    $display("Checks %0d, mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, exp);
    num_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge mclk) {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
    @(posedge mclk) reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk) {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge mclk) reg_rd <= 0;
    #1 d = reg_rdata;
  endtask
  task pulse(input logic [3:0] p);
    @(posedge mclk) evt <= p;
    @(posedge mclk) evt <= 0;
  endtask
  task drain;
    repeat (2) @(posedge mclk);
    #1;
    for (int i = 0; i < 40 && mem_wr_valid; i++) begin
      @(posedge mclk);
      #1;
    end
  endtask
  task quad(input logic [31:0] v);
    @(posedge mclk) {sid_valid, sid_quadlet} <= {1'b1, v};
    @(posedge mclk) {sid_valid, sid_quadlet} <= {1'b0, ~v};
    drain();
  endtask
  // One bus initialization; e is the quadlet before which a receive error strikes
  task sess(input int n, e);
    int c;
    logic [31:0] v;
    pulse(4'h8);
    rd(8'h04); chk(d[10:2], 32'h0);
    pulse(4'h4); ep++; drain();
    c = 1;
    for (int q = 0; q < n; q++) begin
      if (q == e) pulse(4'h1);
      v = (q % 2) ? ~v : $urandom;
      quad(v);
      if (q < e && !herr && c < 512) begin
        sent[c] = v;
        c++;
      end
    end
    pulse(4'h2);
    rd(8'h04); chk(d, {herr || e < n || n > 511, 7'h0, ep, 5'h0,
      n > 511 ? 9'h1ff : (herr ? 9'h0 : 9'(c)), 2'h0});
    if (!herr) chk(i_mem.mem[0][23:16], ep);
    if (!herr) chk(hi, {11'h0, b[31:11]});
    for (int q = 1; q < c && !herr; q++) chk(i_mem.mem[q], sent[q]);
    rd(8'h0c); chk(d[1:0], 32'h3);
    chk(irq, 1'b1);
    wr(8'h0c, 32'h7); #1 chk(irq, 1'b0);
  endtask
  initial begin
    k = $urandom(58423);
    repeat (20) @(posedge mclk);
    rst <= 0;
    rd(8'h00); chk(d, 32'h0);
    rd(8'h14); chk(d, 32'h0);
    b = $urandom;
    wr(8'h00, b); rd(8'h00); chk(d, b & 32'hffff_f800);
    wr(8'h10, 32'h7); wr(8'h08, 32'h1);
    rd(8'h04); ep = d[23:16];
    sess(6, 99); sess(8, 3); sess(4, 99);
    herr = 1; sess(4, 99); herr = 0;
    pulse(4'h8); pulse(4'h4); ep++; quad(32'h0); quad(32'h0); sess(6, 99);
    sess(520, 999);
    for (int i = 0; i < 256; i++) sess(0, 9);
    k = i_mem.n_acc; d = $urandom; quad(d); chk(i_mem.n_acc, k);
    chk(ar_seen, d);
    wr(8'h10, 32'h0); pulse(4'h8); #1 chk(irq, 1'b0);
    wr(8'h10, 32'h1); #1 chk(irq, 1'b1);
    report_and_stop();
  end
endmodule
`default_nettype wire

// >>> testbench/selfid_receive_dma_sva.sv
// Port assertions for the self-ID capture block
`timescale 1ns/1ps
`default_nettype none
module selfid_receive_dma_sva (
  input wire logic        mclk,
  input wire logic        rst,
  input wire logic [7:0]  reg_addr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        bus_reset_start,
  input wire logic        bus_reset_end,
  input wire logic        sid_valid,
  input wire logic [31:0] sid_quadlet,
  input wire logic [6:0]  bus_time_secs,
  input wire logic [12:0] bus_time_cycles,
  input wire logic        ar_req_valid,
  input wire logic [31:0] ar_req_data,
  input wire logic        mem_wr_valid,
  input wire logic [31:0] mem_wr_addr,
  input wire logic [31:0] mem_wr_data,
  input wire logic        mem_wr_ready
);
  wire [15:0] stamp = {bus_time_secs[2:0], bus_time_cycles};
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  property p_rd_idle; !reg_rd |=> reg_rdata == 32'h0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
  property p_base_low; reg_rd && reg_addr == 8'h00 |=> reg_rdata[10:0] == 11'h0; endproperty
  a_base_low: assert property (p_base_low) else $error("base low bits set");
  property p_tally_clr;
    bus_reset_start ##2 (reg_rd && reg_addr == 8'h04) |=> reg_rdata[10:2] == 9'h0; endproperty
  a_tally_clr: assert property (p_tally_clr) else $error("count not cleared");
  property p_hold;
    mem_wr_valid && !mem_wr_ready |=> mem_wr_valid && $stable(mem_wr_addr) && $stable(mem_wr_data);
  endproperty
  a_hold: assert property (p_hold) else $error("write dropped");
  property p_head; $rose(mem_wr_valid) && $past(bus_reset_end, 2) |-> mem_wr_addr[10:0] == 11'h0
    && mem_wr_data[31:24] == 8'h0 && mem_wr_data[15:0] == $past(stamp); endproperty
  a_head: assert property (p_head) else $error("bad header");
  property p_data; $rose(mem_wr_valid) && $past(sid_valid) |-> mem_wr_data == $past(sid_quadlet);
  endproperty
  a_data: assert property (p_data) else $error("bad data");
  property p_ar_src; ar_req_valid |-> $past(sid_valid) && ar_req_data == $past(sid_quadlet);
  endproperty
  a_ar_src: assert property (p_ar_src) else $error("bad routed data");
  property p_ar_only; ar_req_valid |-> !$rose(mem_wr_valid); endproperty
  a_ar_only: assert property (p_ar_only) else $error("routed and stored");
endmodule
bind selfid_receive_dma selfid_receive_dma_sva i_sva (.mclk(mclk), .rst(rst),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .bus_reset_start(bus_reset_start), .bus_reset_end(bus_reset_end), .sid_valid(sid_valid),
  .sid_quadlet(sid_quadlet), .bus_time_secs(bus_time_secs), .bus_time_cycles(bus_time_cycles),
  .ar_req_valid(ar_req_valid), .ar_req_data(ar_req_data), .mem_wr_valid(mem_wr_valid),
  .mem_wr_addr(mem_wr_addr), .mem_wr_data(mem_wr_data), .mem_wr_ready(mem_wr_ready));
`default_nettype wire
